// file: logic/mdma_pkg.sv
package mdma_pkg;
    localparam int unsigned MDMA_NUM_CH    = 13;
    localparam int unsigned MDMA_AW        = 32;
    localparam int unsigned MDMA_DW        = 32;
    localparam int unsigned MDMA_RADDR_W   = 8;
    // Register offsets (byte addresses)
    localparam logic [7:0]  MDMA_REG_CFG        = 8'h00;
    localparam logic [7:0]  MDMA_REG_CTRL_BASE  = 8'h04;
    localparam logic [7:0]  MDMA_REG_ALT_BASE   = 8'h08;
    localparam logic [7:0]  MDMA_REG_ENA_SET    = 8'h0C;
    localparam logic [7:0]  MDMA_REG_ENA_CLR    = 8'h10;
    localparam logic [7:0]  MDMA_REG_PRIO_SET   = 8'h14;
    localparam logic [7:0]  MDMA_REG_PRIO_CLR   = 8'h18;
    localparam logic [7:0]  MDMA_REG_STATUS     = 8'h1C;
    localparam logic [7:0]  MDMA_REG_SWREQ      = 8'h20;
    localparam logic [7:0]  MDMA_REG_ALT_SET    = 8'h24;
    localparam logic [7:0]  MDMA_REG_ALT_CLR    = 8'h28;
    // Control word layout (coined): cycle type, R exponent, count-1, sizes
    localparam int unsigned MDMA_CW_CYC_LSB     = 0;
    localparam int unsigned MDMA_CW_R_LSB       = 14;
    localparam int unsigned MDMA_CW_N_LSB       = 4;
    localparam int unsigned MDMA_CW_SIZE_LSB    = 24;
    localparam int unsigned MDMA_CW_SINC_LSB    = 26;
    localparam int unsigned MDMA_CW_DINC_LSB    = 30;
    // Structure layout: src end, dst end, control, unused; 16 bytes each
    localparam logic [31:0] MDMA_ST_SRC         = 32'h0000_0000;
    localparam logic [31:0] MDMA_ST_DST         = 32'h0000_0004;
    localparam logic [31:0] MDMA_ST_CTL         = 32'h0000_0008;
    localparam int unsigned MDMA_ST_SHIFT       = 4;
    localparam logic [3:0]  MDMA_R_MAX          = 4'hA;

    typedef enum logic [2:0] {
        MDMA_CYC_INVALID   = 3'h0,
        MDMA_CYC_BASIC     = 3'h1,
        MDMA_CYC_AUTO      = 3'h2,
        MDMA_CYC_PINGPONG  = 3'h3,
        MDMA_CYC_MSG_PRI   = 3'h4,
        MDMA_CYC_MSG_ALT   = 3'h5,
        MDMA_CYC_PSG_PRI   = 3'h6,
        MDMA_CYC_PSG_ALT   = 3'h7
    } mdma_cyc_t;

    // AHB-Lite encodings
    localparam logic [1:0]  MDMA_HTRANS_IDLE    = 2'h0;
    localparam logic [1:0]  MDMA_HTRANS_NONSEQ  = 2'h2;
    localparam logic [2:0]  MDMA_HBURST_SINGLE  = 3'h0;
    localparam logic [2:0]  MDMA_HSIZE_WORD     = 3'h2;
endpackage

// file: logic/mdma_arbiter.sv
`timescale 1ns/1ps
module mdma_arbiter #(
    parameter int unsigned NCH = 13
) (
    // Requests
    input  wire logic [NCH-1:0] pend,
    input  wire logic [NCH-1:0] high,
    // Grant
    output logic                found,
    output logic [3:0]          chan
);
    function automatic logic [4:0] mdma_first(input logic [NCH-1:0] v);
        logic [4:0] r;
        r = 5'h1F;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    logic [4:0] hi_idx;
    logic [4:0] lo_idx;

    always_comb begin
        hi_idx = mdma_first(pend & high);
        lo_idx = mdma_first(pend & ~high);
        found  = |pend;
        // High level first, then lowest number
        if (hi_idx != 5'h1F) begin
            chan = hi_idx[3:0];
        end else begin
            chan = lo_idx[3:0];
        end
    end
endmodule

// file: logic/mdma_top.sv
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module mdma_top
    import mdma_pkg::*;
#(
    parameter int unsigned NCH = mdma_pkg::MDMA_NUM_CH
) (
    // Clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst,
    // Register port
    input  wire logic [mdma_pkg::MDMA_RADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]                         reg_wdata,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    output logic      [31:0]                         reg_rdata,
    // Channel handshakes
    input  wire logic [NCH-1:0]                      dma_req,
    output logic      [NCH-1:0]                      dma_done,
    // AHB-Lite master
    output logic      [mdma_pkg::MDMA_AW-1:0]        haddr,
    output logic      [1:0]                          htrans,
    output logic                                     hwrite,
    output logic      [2:0]                          hsize,
    output logic      [2:0]                          hburst,
    output logic      [mdma_pkg::MDMA_DW-1:0]        hwdata,
    input  wire logic [mdma_pkg::MDMA_DW-1:0]        hrdata,
    input  wire logic                                hready,
    input  wire logic                                hresp
);
    import mdma_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_FSRC  = 4'b0001,
        ST_FDST  = 4'b0011,
        ST_FCTL  = 4'b0010,
        ST_RD    = 4'b0110,
        ST_WR    = 4'b0111,
        ST_WDONE = 4'b0101,
        ST_WBCTL = 4'b0100,
        ST_ERR   = 4'b1100
    } mdma_state_t;

    // Request synchronisers
    logic [NCH-1:0] req_s1_reg, req_s2_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            req_s1_reg <= '0;
            req_s2_reg <= '0;
        end else begin
            req_s1_reg <= dma_req;
            req_s2_reg <= req_s1_reg;
        end
    end

    // Registers
    logic           master_en_reg, master_en_next;
    logic [31:0]    base_reg, base_next;
    logic [NCH-1:0] ena_reg, ena_next;
    logic [NCH-1:0] prio_reg, prio_next;
    logic [NCH-1:0] alt_reg, alt_next;
    logic [NCH-1:0] swreq_reg, swreq_next;
    logic [NCH-1:0] pend_reg, pend_next;
    logic           buserr_reg, buserr_next;
    logic [31:0]    rdata_reg, rdata_next;

    // Engine state
    mdma_state_t    st_reg, st_next;
    logic [3:0]     ch_reg, ch_next;
    logic           use_alt_reg, use_alt_next;
    logic [31:0]    src_end_reg, src_end_next;
    logic [31:0]    dst_end_reg, dst_end_next;
    logic [31:0]    ctl_reg, ctl_next;
    logic [10:0]    left_reg, left_next;
    logic [10:0]    grp_reg, grp_next;
    logic [NCH-1:0] done_reg, done_next;
    logic [31:0]    haddr_reg, haddr_next;
    logic [1:0]     htrans_reg, htrans_next;
    logic           hwrite_reg, hwrite_next;
    logic [2:0]     hsize_reg, hsize_next;
    logic [31:0]    hwdata_reg, hwdata_next;

    logic           arb_found;
    logic [3:0]     arb_chan;
    // Rearbitration interval, capped at 1024
    function automatic logic [10:0] mdma_group(input logic [3:0] r);
        return 11'(11'h001 << ((r >= MDMA_R_MAX) ? MDMA_R_MAX : r));
    endfunction

    // Address of the transfer nleft from the end, counted back from the end pointer
    function automatic logic [31:0] mdma_addr(input logic [31:0] endp,
                                              input logic [1:0]  inc,
                                              input logic [10:0] nleft);
        // increment code may exceed the transfer width; code 3 holds still
        return (inc == 2'h3) ? endp : endp - ((32'(nleft) - 32'h1) << inc);
    endfunction

    mdma_arbiter #(.NCH(NCH)) mdma_arbiter_inst (
        .pend  (pend_reg & ena_reg),
        .high  (prio_reg),
        .found (arb_found),
        .chan  (arb_chan)
    );

    logic [31:0] st_base;
    logic [1:0]  sz_code;
    mdma_cyc_t   cyc;

    always_comb begin
        sz_code   = ctl_reg[MDMA_CW_SIZE_LSB +: 2];
        cyc       = mdma_cyc_t'(ctl_reg[MDMA_CW_CYC_LSB +: 3]);
        st_base   = (use_alt_reg ? base_reg + 32'(NCH) * 32'h10 : base_reg)
                  + (32'(ch_reg) << MDMA_ST_SHIFT);
    end

    // Register port and channel bookkeeping
    always_comb begin
        master_en_next = master_en_reg;
        base_next      = base_reg;
        ena_next       = ena_reg;
        prio_next      = prio_reg;
        alt_next       = alt_reg;
        swreq_next     = '0;
        rdata_next     = 32'h0000_0000;
        pend_next      = pend_reg | req_s2_reg | swreq_reg;
        if (reg_wr) begin
            case (reg_addr)
                MDMA_REG_CFG:       master_en_next = reg_wdata[0];
                MDMA_REG_CTRL_BASE: base_next      = reg_wdata;
                MDMA_REG_ENA_SET:   ena_next       = ena_reg | reg_wdata[NCH-1:0];
                MDMA_REG_ENA_CLR:   ena_next       = ena_reg & ~reg_wdata[NCH-1:0];
                MDMA_REG_PRIO_SET:  prio_next      = prio_reg | reg_wdata[NCH-1:0];
                MDMA_REG_PRIO_CLR:  prio_next      = prio_reg & ~reg_wdata[NCH-1:0];
                MDMA_REG_SWREQ:     swreq_next     = reg_wdata[NCH-1:0];
                MDMA_REG_ALT_SET:   alt_next       = alt_reg | reg_wdata[NCH-1:0];
                MDMA_REG_ALT_CLR:   alt_next       = alt_reg & ~reg_wdata[NCH-1:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                MDMA_REG_CFG:       rdata_next = {31'h0, master_en_reg};
                MDMA_REG_CTRL_BASE: rdata_next = base_reg;
                MDMA_REG_ALT_BASE:  rdata_next = base_reg + 32'(NCH) * 32'h10;
                MDMA_REG_ENA_SET:   rdata_next = 32'(ena_reg);
                MDMA_REG_PRIO_SET:  rdata_next = 32'(prio_reg);
                MDMA_REG_ALT_SET:   rdata_next = 32'(alt_reg);
                MDMA_REG_STATUS:    rdata_next = {buserr_reg, 3'h0, st_reg, ch_reg,
                                                  3'h0, 17'(pend_reg)};
                default:            rdata_next = 32'h0000_0000;
            endcase
        end
        // Engine takes the request when it starts a group
        if (st_reg == ST_IDLE && arb_found && master_en_reg && hready) begin
            pend_next[arb_chan] = req_s2_reg[arb_chan] | swreq_reg[arb_chan];
        end
        if (st_reg == ST_WBCTL && hready && left_reg != 11'h000 && cyc == MDMA_CYC_AUTO) begin
            pend_next[ch_reg] = 1'b1;
        end
        // Channel finished: drop it, or for ping-pong keep it and flip its side
        for (int i = 0; i < NCH; i++) begin
            if (done_next[i]) begin
                if (cyc == MDMA_CYC_PINGPONG) begin
                    alt_next[i] = ~alt_reg[i];
                end else begin
                    ena_next[i] = 1'b0;
                end
            end
        end
    end

    // Transfer engine
    always_comb begin
        st_next      = st_reg;
        ch_next      = ch_reg;
        use_alt_next = use_alt_reg;
        src_end_next = src_end_reg;
        dst_end_next = dst_end_reg;
        ctl_next     = ctl_reg;
        left_next    = left_reg;
        grp_next     = grp_reg;
        done_next    = '0;
        buserr_next  = buserr_reg;
        haddr_next   = haddr_reg;
        htrans_next  = hready ? MDMA_HTRANS_IDLE : htrans_reg;
        hwrite_next  = hready ? 1'b0 : hwrite_reg;
        hsize_next   = hsize_reg;
        hwdata_next  = hwdata_reg;
        if (hready) begin
            case (st_reg)
                ST_IDLE: begin
                    if (arb_found && master_en_reg) begin
                        st_next      = ST_FSRC;
                        ch_next      = arb_chan;
                        use_alt_next = alt_reg[arb_chan];
                    end
                end
                ST_FSRC: begin
                    haddr_next  = st_base + MDMA_ST_SRC;
                    htrans_next = MDMA_HTRANS_NONSEQ;
                    hsize_next  = MDMA_HSIZE_WORD;
                    st_next     = ST_FDST;
                end
                ST_FDST: begin
                    haddr_next  = st_base + MDMA_ST_DST;
                    htrans_next = MDMA_HTRANS_NONSEQ;
                    st_next     = ST_FCTL;
                end
                ST_FCTL: begin
                    haddr_next   = st_base + MDMA_ST_CTL;
                    htrans_next  = MDMA_HTRANS_NONSEQ;
                    src_end_next = hrdata;
                    st_next      = ST_RD;
                    left_next    = 11'h000;
                end
                ST_RD: begin
                    if (left_reg == 11'h000 && htrans_reg != MDMA_HTRANS_IDLE) begin
                        dst_end_next = hrdata;
                    end else if (left_reg == 11'h000) begin
                        ctl_next  = hrdata;
                        left_next = 11'(hrdata[MDMA_CW_N_LSB +: 10]) + 11'h001;
                        grp_next  = mdma_group(hrdata[MDMA_CW_R_LSB +: 4]);
                        if (hrdata[MDMA_CW_CYC_LSB +: 3] == MDMA_CYC_INVALID) begin
                            st_next = ST_IDLE;
                        end
                    end else begin
                        haddr_next  = mdma_addr(src_end_reg, ctl_reg[MDMA_CW_SINC_LSB +: 2],
                                                left_reg);
                        hsize_next  = {1'b0, sz_code};
                        htrans_next = MDMA_HTRANS_NONSEQ;
                        st_next     = ST_WR;
                    end
                end
                ST_WR: begin
                    haddr_next  = mdma_addr(dst_end_reg, ctl_reg[MDMA_CW_DINC_LSB +: 2],
                                            left_reg);
                    htrans_next = MDMA_HTRANS_NONSEQ;
                    hwrite_next = 1'b1;
                    st_next     = ST_WDONE;
                end
                ST_WDONE: begin
                    hwdata_next = hrdata;
                    left_next   = left_reg - 11'h001;
                    grp_next    = grp_reg - 11'h001;
                    if (left_reg == 11'h001) begin
                        st_next = ST_WBCTL;
                    end else if (grp_reg == 11'h001) begin
                        // group done, store the count left, rearbitrate
                        st_next = ST_WBCTL;
                    end else begin
                        st_next = ST_RD;
                    end
                end
                ST_WBCTL: begin
                    haddr_next  = st_base + MDMA_ST_CTL;
                    htrans_next = MDMA_HTRANS_NONSEQ;
                    hwrite_next = 1'b1;
                    hsize_next  = MDMA_HSIZE_WORD;
                    hwdata_next = {ctl_reg[31:3], 3'(MDMA_CYC_INVALID)};
                    if (left_reg != 11'h000) begin
                        hwdata_next = ctl_reg;
                        hwdata_next[MDMA_CW_N_LSB +: 10] = 10'(left_reg - 11'h001);
                    end
                    done_next[ch_reg] = (left_reg == 11'h000)
                                     && ((cyc == MDMA_CYC_BASIC) || (cyc == MDMA_CYC_AUTO)
                                     || (cyc == MDMA_CYC_PINGPONG) || (cyc == MDMA_CYC_MSG_ALT)
                                     || (cyc == MDMA_CYC_PSG_ALT));
                    st_next     = ST_IDLE;
                end
                ST_ERR:  st_next = ST_ERR;
                default: st_next = ST_IDLE;
            endcase
            if (hresp) begin
                buserr_next = 1'b1;
                st_next     = ST_ERR;
            end
        end
        if (st_reg == ST_ERR && !master_en_reg) begin
            st_next     = ST_IDLE;
            buserr_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            master_en_reg <= 1'b0;
            base_reg      <= 32'h0000_0000;
            ena_reg       <= '0;
            prio_reg      <= '0;
            alt_reg       <= '0;
            swreq_reg     <= '0;
            pend_reg      <= '0;
            buserr_reg    <= 1'b0;
            rdata_reg     <= 32'h0000_0000;
            st_reg        <= ST_IDLE;
            ch_reg        <= 4'h0;
            use_alt_reg   <= 1'b0;
            src_end_reg   <= 32'h0000_0000;
            dst_end_reg   <= 32'h0000_0000;
            ctl_reg       <= 32'h0000_0000;
            left_reg      <= 11'h000;
            grp_reg       <= 11'h000;
            done_reg      <= '0;
            haddr_reg     <= 32'h0000_0000;
            htrans_reg    <= MDMA_HTRANS_IDLE;
            hwrite_reg    <= 1'b0;
            hsize_reg     <= MDMA_HSIZE_WORD;
            hwdata_reg    <= 32'h0000_0000;
        end else begin
            master_en_reg <= master_en_next;
            base_reg      <= base_next;
            ena_reg       <= ena_next;
            prio_reg      <= prio_next;
            alt_reg       <= alt_next;
            swreq_reg     <= swreq_next;
            pend_reg      <= pend_next;
            buserr_reg    <= buserr_next;
            rdata_reg     <= rdata_next;
            st_reg        <= st_next;
            ch_reg        <= ch_next;
            use_alt_reg   <= use_alt_next;
            src_end_reg   <= src_end_next;
            dst_end_reg   <= dst_end_next;
            ctl_reg       <= ctl_next;
            left_reg      <= left_next;
            grp_reg       <= grp_next;
            done_reg      <= done_next;
            haddr_reg     <= haddr_next;
            htrans_reg    <= htrans_next;
            hwrite_reg    <= hwrite_next;
            hsize_reg     <= hsize_next;
            hwdata_reg    <= hwdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign dma_done  = done_reg;
    assign haddr     = haddr_reg;
    assign htrans    = htrans_reg;
    assign hwrite    = hwrite_reg;
    assign hsize     = hsize_reg;
    assign hburst    = MDMA_HBURST_SINGLE;
    assign hwdata    = hwdata_reg;
endmodule

// file: test/mdma_ahb_mem.sv
`timescale 1ns/1ps
module mdma_ahb_mem (
    // Clock, reset, pacing
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        stall,
    // AHB-Lite slave side
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hready,
    output logic             hresp
);
    logic [31:0] mem [0:255];
    logic        ph_v, ph_w, tick;
    logic [7:0]  ph_a;
    int          nwr;
    // Slow mode answers every other cycle
    assign hready = !stall || tick;
    assign hresp  = 1'b0;
    // Idle data bus toggles so stale data never looks valid
    assign hrdata = (ph_v && !ph_w) ? mem[ph_a] : {16{tick, !tick}};
    always @(posedge clk) begin
        tick <= rst ? 1'b0 : !tick;
        if (rst) begin
            ph_v <= 1'b0;
            ph_w <= 1'b0;
            ph_a <= 8'h00;
            nwr  <= 0;
        end else if (hready) begin
            if (ph_v && ph_w) mem[ph_a] <= hwdata;
            if (ph_v && ph_w && ph_a >= 8'hC0) nwr <= nwr + 1;
            ph_v <= htrans[1];
            ph_w <= hwrite;
            ph_a <= haddr[9:2];
        end
    end
endmodule

// file: test/mdma_top_asserts.sv
`timescale 1ns/1ps
module mdma_top_asserts
    import mdma_pkg::*;
#(
    parameter int unsigned NCH = 13
) (
    input wire logic           clk,
    input wire logic           rst,
    input wire logic           reg_rd,
    input wire logic [31:0]    reg_rdata,
    input wire logic [NCH-1:0] dma_done,
    input wire logic [31:0]    haddr,
    input wire logic [1:0]     htrans,
    input wire logic           hwrite,
    input wire logic [2:0]     hsize,
    input wire logic [2:0]     hburst,
    input wire logic           hready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_single; hburst == MDMA_HBURST_SINGLE; endproperty
    a_single: assert property (p_single) else $error("burst not single");
    property p_trans; htrans == MDMA_HTRANS_IDLE || htrans == MDMA_HTRANS_NONSEQ; endproperty
    a_trans: assert property (p_trans) else $error("htrans not idle or nonseq");
    property p_pulse; dma_done != '0 |=> (dma_done & $past(dma_done)) == '0; endproperty
    a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
    property p_one; $onehot0(dma_done); endproperty
    a_one: assert property (p_one) else $error("two channels done at once");
    property p_rdata; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
    property p_hold;
        htrans == MDMA_HTRANS_NONSEQ && !hready |=>
            htrans == MDMA_HTRANS_NONSEQ && $stable(haddr) && $stable(hwrite);
    endproperty
    a_hold: assert property (p_hold) else $error("address phase moved in wait");
    property p_align; htrans[1] && hsize == MDMA_HSIZE_WORD |-> haddr[1:0] == 2'h0; endproperty
    a_align: assert property (p_align) else $error("word access misaligned");
    property p_size; htrans[1] |-> hsize <= MDMA_HSIZE_WORD; endproperty
    a_size: assert property (p_size) else $error("size above word");
    property p_rst; $fell(rst) |-> htrans == MDMA_HTRANS_IDLE && dma_done == '0; endproperty
    a_rst: assert property (p_rst) else $error("bus busy out of reset");
    c_done: cover property (dma_done != '0);
    c_stall: cover property (htrans[1] && !hready);
    c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind mdma_top mdma_top_asserts #(.NCH(NCH)) mdma_top_asserts_inst (.clk(clk), .rst(rst),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_done(dma_done), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(hburst), .hready(hready));

// file: test/mdma_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
    $display("Error %s exp %h got %h", nm, e, a); end end
module mdma_top_tb;
    import mdma_pkg::*;
    logic        clk, rst, reg_wr, reg_rd, hwrite, hready, hresp, stall;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, haddr, hwdata, hrdata;
    logic [12:0] dma_req, dma_done;
    logic [1:0]  htrans;
    logic [2:0]  hsize, hburst;
    int          n_errors, samples_checked;
    mdma_top mdma_top_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_req(dma_req),
        .dma_done(dma_done), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hburst(hburst), .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp));
    mdma_ahb_mem mdma_ahb_mem_inst (.clk(clk), .rst(rst), .stall(stall), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
        .hready(hready), .hresp(hresp));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 `CHK(nm, e, reg_rdata)
    endtask
    function automatic logic [31:0] ctl(input logic [2:0] c, input logic [9:0] nm1,
                                        input logic [3:0] r);
        return {2'h3, 2'h0, 2'h3, 2'h2, 6'h00, r, nm1, 1'b0, c};
    endfunction
    // Structure with fixed source and destination words
    task automatic setup(input int ch, input logic [31:0] cw);
        mdma_ahb_mem_inst.mem[ch*4]   = 32'h0000_0300;
        mdma_ahb_mem_inst.mem[ch*4+1] = 32'h0000_0340;
        mdma_ahb_mem_inst.mem[ch*4+2] = cw;
    endtask
    task automatic go(input int ch, input bit hw, input int lim, input bit want,
                      output int nw, output bit dn);
        int w0;
        w0 = mdma_ahb_mem_inst.nwr;
        dn = 1'b0;
        if (hw) begin
            @(posedge clk);
            dma_req <= 13'h1 << ch;
            repeat (3) @(posedge clk);
            dma_req <= 13'h0;
        end else begin
            wr(MDMA_REG_SWREQ, 32'h1 << ch);
        end
        for (int i = 0; i < lim && !dn; i++) begin
            @(posedge clk);
            #1 if (dma_done[ch] === 1'b1) dn = 1'b1;
        end
        repeat (8) @(posedge clk);
        nw = mdma_ahb_mem_inst.nwr - w0;
        if (want && !dn) begin
            n_errors++;
            final_report();
        end
    endtask
    task automatic t_regs;
        wr(MDMA_REG_CTRL_BASE, 32'h0);
        rd(MDMA_REG_ALT_BASE, 32'h0000_00D0, "alt_base");
        rd(8'hFC, 32'h0, "unmapped");
        wr(MDMA_REG_PRIO_SET, 32'h0000_0020);
        rd(MDMA_REG_PRIO_SET, 32'h0000_0020, "prio_set");
        wr(MDMA_REG_PRIO_CLR, 32'h0000_0020);
        rd(MDMA_REG_PRIO_SET, 32'h0, "prio_clr");
        wr(MDMA_REG_CFG, 32'h1);
        $display("test regs end");
    endtask
    task automatic t_auto;
        int nw;
        bit dn;
        stall <= 1'b1;
        setup(2, ctl(3'h2, 10'd3, 4'h0));
        mdma_ahb_mem_inst.mem[8'hC0] = 32'h1234_5678;
        wr(MDMA_REG_ENA_SET, 32'h4);
        go(2, 0, 400, 1, nw, dn);
        `CHK("auto_writes", 4, nw)
        `CHK("auto_dst", 32'h1234_5678, mdma_ahb_mem_inst.mem[8'hD0])
        `CHK("auto_cyc", 3'h0, mdma_ahb_mem_inst.mem[10][2:0])
        rd(MDMA_REG_ENA_SET, 32'h0, "auto_ena");
        stall <= 1'b0;
        $display("test auto end");
    endtask
    task automatic t_basic;
        int nw;
        bit dn;
        setup(3, ctl(3'h1, 10'd1, 4'h0));
        setup(7, ctl(3'h0, 10'd1, 4'h0));
        wr(MDMA_REG_ENA_SET, 32'h88);
        go(3, 0, 80, 0, nw, dn);
        `CHK("basic_one", 1, nw)
        `CHK("basic_nodone", 1'b0, dn)
        go(3, 1, 200, 1, nw, dn);
        `CHK("basic_two", 1, nw)
        go(7, 0, 80, 0, nw, dn);
        `CHK("inval_writes", 0, nw)
        `CHK("inval_done", 1'b0, dn)
        $display("test basic end");
    endtask
    task automatic t_rpow;
        int nw;
        bit dn;
        logic [3:0] rr [2] = '{4'h1, 4'hF};
        int cnt [2] = '{5, 3};
        wr(MDMA_REG_PRIO_SET, 32'h40);
        for (int k = 0; k < 2; k++) begin
            setup(6, ctl(3'h2, 10'(cnt[k] - 1), rr[k]));
            wr(MDMA_REG_ENA_SET, 32'h40);
            go(6, 0, 400, 1, nw, dn);
            `CHK("rpow_writes", cnt[k], nw)
        end
        $display("test rpow end");
    endtask
    task automatic t_prio;
        int got[$];
        wr(MDMA_REG_CFG, 32'h0);
        setup(1, ctl(3'h1, 10'd0, 4'h0));
        setup(4, ctl(3'h1, 10'd0, 4'h0));
        setup(5, ctl(3'h1, 10'd0, 4'h0));
        wr(MDMA_REG_ENA_SET, 32'h32);
        wr(MDMA_REG_PRIO_SET, 32'h20);
        wr(MDMA_REG_SWREQ, 32'h32);
        wr(MDMA_REG_CFG, 32'h1);
        for (int i = 0; i < 400 && got.size() < 3; i++) begin
            @(posedge clk);
            #1 for (int c = 0; c < 13; c++) if (dma_done[c] === 1'b1) got.push_back(c);
        end
        if (got.size() < 3) begin
            n_errors++;
            final_report();
        end
        `CHK("prio_first", 5, got[0])
        `CHK("prio_second", 1, got[1])
        `CHK("prio_third", 4, got[2])
        $display("test prio end");
    endtask
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        dma_req = 13'h0;
        stall = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_auto();
        t_basic();
        t_rpow();
        t_prio();
        final_report();
    end
endmodule
